/* File: verilog/rure_map.svh */
// constants of the remote unit request exchange
`ifndef RURE_MAP_SVH
`define RURE_MAP_SVH
`define RURE_CLK_PERIOD_PS 5000
`define RURE_US_CYC (1000000 / `RURE_CLK_PERIOD_PS)
`define RURE_MS_US 1000
`define RURE_HB_TIMEOUT_S 60
`define RURE_HB_TIMEOUT_CYC (64'd60 * 64'd200000000)
`define RURE_HB_MAX_MS 16'd60000
`define RURE_BFM_HEARTBEAT 16'h0018
`define RURE_BFM_STATUS 16'h0020
`define RURE_ONLINE_BIT 0
`define RURE_IN_LO 16'd1024
`define RURE_IN_HI 16'd16383
`define RURE_FL_BLK1_LO 16'd1536
`define RURE_FL_BLK1_HI 16'd1543
`define RURE_FL_BLK2_LO 16'd16896
`define RURE_FL_BLK2_HI 16'd16903
`define RURE_FLAG_SET 8'h01
`define RURE_REG_CTRL 8'h00
`define RURE_REG_ADDR 8'h04
`define RURE_REG_DATA 8'h08
`define RURE_REG_FLAGS 8'h0C
`define RURE_REG_TMO 8'h10
`define RURE_REG_HBP 8'h14
`define RURE_REG_STAT 8'h18
`define RURE_REG_SEQ 8'h1C
`define RURE_REG_RXD 8'h20
`define RURE_REG_ERR 8'h24
`define RURE_REG_CODE 8'h28
`define RURE_REG_RXCODE 8'h2C
`define RURE_ERR_OPEN_NOLINK 16'h0001
`define RURE_ERR_TX_NOTOPEN 16'h0002
`define RURE_ERR_RX_LINKDROP 16'h0003
`endif

/* File: verilog/rure_pkg.sv */
// types of the request exchange; only the request kind is shared by both ends
package rure_pkg;
	typedef enum logic [1:0] {
		RURE_K_HB = 2'b00,
		RURE_K_WR = 2'b01,
		RURE_K_RD = 2'b10,
		RURE_K_FL = 2'b11
	} rure_kind_e;
	typedef enum logic [1:0] {
		RURE_S_IDLE = 2'b00,
		RURE_S_SEND = 2'b01,
		RURE_S_WAIT = 2'b10
	} rure_state_e;
	function automatic logic rure_in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		rure_in_range = (a >= lo) && (a <= hi);
	endfunction
endpackage

/* File: verilog/rure_link_if.sv */
// link between controller and remote unit
`timescale 1ns/1ps
`default_nettype none
interface rure_link_if;
	logic req_valid;
	logic req_ready;
	rure_pkg::rure_kind_e req_kind;
	logic [15:0] req_addr;
	logic [15:0] req_data;
	logic [15:0] req_flags;
	logic [15:0] req_seq;
	logic rsp_valid;
	logic [15:0] rsp_seq;
	logic [15:0] rsp_data;
	modport ctrl (output req_valid, req_kind, req_addr, req_data, req_flags, req_seq,
		input req_ready, rsp_valid, rsp_seq, rsp_data);
	modport unit (input req_valid, req_kind, req_addr, req_data, req_flags, req_seq,
		output req_ready, rsp_valid, rsp_seq, rsp_data);
endinterface
`default_nettype wire

/* File: verilog/rure_unit.sv */
// remote unit end: buffer memory, flags, heartbeat watch
`timescale 1ns/1ps
`default_nettype none
`include "rure_map.svh"
module rure_unit #(
	parameter logic [63:0] HB_LIMIT = `RURE_HB_TIMEOUT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	rure_link_if.unit link,
	input wire logic hold_rsp,
	input wire logic [15:0] peek_addr,
	output logic [15:0] peek_value,
	output logic [7:0] peek_flags,
	output logic [15:0] comm_status,
	output logic [15:0] heartbeat_word
);
	logic [15:0] value_mem [0:255];
	logic [7:0] flag_mem [0:255];
	logic [63:0] hb_cnt_reg;
	logic rd_pend_reg;
	logic [15:0] rd_seq_reg;
	logic [15:0] rd_addr_reg;

	// request decode
	wire take = link.req_valid && link.req_ready;
	wire [7:0] idx = link.req_addr[7:0];
	wire is_wr = take && (link.req_kind == rure_pkg::RURE_K_WR);
	wire is_fl = take && (link.req_kind == rure_pkg::RURE_K_FL);
	wire is_hb = take && (link.req_kind == rure_pkg::RURE_K_HB);
	wire is_rd = take && (link.req_kind == rure_pkg::RURE_K_RD);
	wire at_1024 = link.req_addr == `RURE_IN_LO;
	wire comb_flags = link.req_flags[15:8] == `RURE_FLAG_SET;
	wire in_area = rure_pkg::rure_in_range(link.req_addr, `RURE_IN_LO, `RURE_IN_HI);
	wire val_we = is_wr && !at_1024;
	wire comb_fl_we = val_we && comb_flags && in_area;
	wire blk1 = rure_pkg::rure_in_range(link.req_addr, `RURE_FL_BLK1_LO, `RURE_FL_BLK1_HI);
	wire blk2 = rure_pkg::rure_in_range(link.req_addr, `RURE_FL_BLK2_LO, `RURE_FL_BLK2_HI);
	wire dir_fl_we = is_fl && !blk1 && !blk2;
	wire hb_we = (is_hb || val_we) && (link.req_addr == `RURE_BFM_HEARTBEAT);
	wire hb_changed = hb_we && (link.req_data != heartbeat_word);

	// memories, no reset
	always_ff @(posedge pclk)
	begin
		if (val_we)
			value_mem[idx] <= link.req_data;
		if (comb_fl_we)
			flag_mem[idx] <= link.req_flags[7:0];
		else if (dir_fl_we)
			flag_mem[idx] <= link.req_data[7:0];
		peek_value <= value_mem[peek_addr[7:0]];
		peek_flags <= flag_mem[peek_addr[7:0]];
	end

	// heartbeat watchdog drives online bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hb_cnt_reg <= 64'h0;
			heartbeat_word <= 16'h0;
			comm_status <= 16'h0;
		end
		else
		begin
			if (hb_we)
				heartbeat_word <= link.req_data;
			if (hb_changed)
			begin
				hb_cnt_reg <= 64'h0;
				comm_status[`RURE_ONLINE_BIT] <= 1'b1;
			end
			else if (hb_cnt_reg >= HB_LIMIT - 64'h1)
				comm_status[`RURE_ONLINE_BIT] <= 1'b0;
			else
				hb_cnt_reg <= hb_cnt_reg + 64'h1;
		end
	end

	// read answer, held off by hold_rsp
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_pend_reg <= 1'b0;
			rd_seq_reg <= 16'h0;
			rd_addr_reg <= 16'h0;
			link.req_ready <= 1'b0;
			link.rsp_valid <= 1'b0;
			link.rsp_seq <= 16'h0;
			link.rsp_data <= 16'h0;
		end
		else
		begin
			link.rsp_valid <= 1'b0;
			link.req_ready <= !rd_pend_reg && !is_rd;
			if (is_rd)
			begin
				rd_pend_reg <= 1'b1;
				rd_seq_reg <= link.req_seq;
				rd_addr_reg <= link.req_addr;
			end
			else if (rd_pend_reg && !hold_rsp)
			begin
				rd_pend_reg <= 1'b0;
				link.rsp_valid <= 1'b1;
				link.rsp_seq <= rd_seq_reg;
				link.rsp_data <= value_mem[rd_addr_reg[7:0]];
			end
		end
	end
endmodule
`default_nettype wire

/* File: verilog/rure_ctrl.sv */
// controller end: apb registers, heartbeat, one-at-a-time requests
`timescale 1ns/1ps
`default_nettype none
`include "rure_map.svh"
module rure_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cable_link_ok,
	output logic connection_open_done,
	output logic send_done,
	output logic receive_done,
	output logic response_timeout_err,
	output logic cable_link_err,
	rure_link_if.ctrl link
);
	logic link_s1_reg;
	logic link_s2_reg;
	logic enable_reg;
	logic [15:0] addr_reg;
	logic [15:0] data_reg;
	logic [15:0] flags_reg;
	logic [15:0] tmo_us_reg;
	logic [15:0] hbp_ms_reg;
	logic cmd_pend_reg;
	rure_pkg::rure_kind_e cmd_kind_reg;
	rure_pkg::rure_state_e state_reg;
	logic cur_hb_reg;
	logic hb_pend_reg;
	logic [15:0] hb_val_reg;
	logic [7:0] us_pre_reg;
	logic [9:0] ms_pre_reg;
	logic [15:0] hb_ms_reg;
	logic [15:0] tmo_cnt_reg;
	logic [15:0] request_seq_id;
	logic [15:0] response_seq_id;
	logic [15:0] rx_area_head;
	logic conn_open_err;
	logic tx_err;
	logic rx_err;
	logic [15:0] conn_open_err_code;
	logic [15:0] tx_err_code;
	logic [15:0] rx_err_code;

	// apb decode; write and read take effect when pready is seen high
	wire acc = psel && penable && pready;
	wire wr = acc && pwrite;
	wire w_ctrl = wr && (paddr == `RURE_REG_CTRL);
	wire w_err = wr && (paddr == `RURE_REG_ERR);
	wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `RURE_REG_CODE);
	wire link_up = link_s2_reg;
	wire open_now = enable_reg && link_up;
	wire open_rise = open_now && !connection_open_done;
	wire cmd_go = w_ctrl && pwdata[1]; // bit1 launches, bits 3:2 kind
	wire us_tick = us_pre_reg == 8'(`RURE_US_CYC - 1);
	wire ms_tick = us_tick && (ms_pre_reg == 10'(`RURE_MS_US - 1));
	wire [15:0] hbp_wr = (pwdata[15:0] > `RURE_HB_MAX_MS) ? `RURE_HB_MAX_MS : pwdata[15:0];
	wire [15:0] hbp_eff = (hbp_ms_reg > `RURE_HB_MAX_MS) ? `RURE_HB_MAX_MS : hbp_ms_reg;
	wire hb_due = ms_tick && (hbp_eff != 16'h0) && (hb_ms_reg >= hbp_eff - 16'h1);
	wire hs = link.req_valid && link.req_ready;
	wire waiting = state_reg == rure_pkg::RURE_S_WAIT;
	wire match = waiting && link.rsp_valid && (link.rsp_seq == request_seq_id);
	wire expire = waiting && !match && us_tick && (tmo_cnt_reg >= tmo_us_reg);
	wire drop = waiting && !link_up;
	wire tx_fail = cmd_go && !open_now;
	wire open_fail = w_ctrl && pwdata[0] && !link_up;
	wire busy = cmd_pend_reg || (state_reg != rure_pkg::RURE_S_IDLE);

	// read mux
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0;
		case (paddr)
			`RURE_REG_CTRL: rd_mux = {31'h0, enable_reg};
			`RURE_REG_ADDR: rd_mux = {16'h0, addr_reg};
			`RURE_REG_DATA: rd_mux = {16'h0, data_reg};
			`RURE_REG_FLAGS: rd_mux = {16'h0, flags_reg};
			`RURE_REG_TMO: rd_mux = {16'h0, tmo_us_reg};
			`RURE_REG_HBP: rd_mux = {16'h0, hbp_ms_reg};
			`RURE_REG_STAT: rd_mux = {28'h0, busy, link_up, connection_open_done, hb_pend_reg};
			`RURE_REG_SEQ: rd_mux = {response_seq_id, request_seq_id};
			`RURE_REG_RXD: rd_mux = {16'h0, rx_area_head};
			`RURE_REG_ERR: rd_mux = {28'h0, cable_link_err, rx_err, tx_err, conn_open_err};
			`RURE_REG_CODE: rd_mux = {tx_err_code, conn_open_err_code};
			default: rd_mux = 32'h0;
		endcase
	end

	// apb answer one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			prdata <= (paddr == `RURE_REG_RXCODE) ? {16'h0, rx_err_code} : rd_mux;
		end
	end

	// cable link synchroniser
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link_s1_reg <= 1'b0;
			link_s2_reg <= 1'b0;
			cable_link_err <= 1'b1;
		end
		else
		begin
			link_s1_reg <= cable_link_ok;
			link_s2_reg <= link_s1_reg;
			cable_link_err <= !link_s2_reg;
		end
	end

	// software settings
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_reg <= 1'b0;
			addr_reg <= 16'h0;
			data_reg <= 16'h0;
			flags_reg <= 16'h0;
			tmo_us_reg <= 16'h0;
			hbp_ms_reg <= 16'h0;
		end
		else if (wr)
		begin
			case (paddr)
				`RURE_REG_CTRL: enable_reg <= pwdata[0];
				`RURE_REG_ADDR: addr_reg <= pwdata[15:0];
				`RURE_REG_DATA: data_reg <= pwdata[15:0];
				`RURE_REG_FLAGS: flags_reg <= pwdata[15:0];
				`RURE_REG_TMO: tmo_us_reg <= pwdata[15:0];
				`RURE_REG_HBP: hbp_ms_reg <= hbp_wr; // stored setting never above the limit
				default: ;
			endcase
		end
	end

	// time base and heartbeat scheduling
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			us_pre_reg <= 8'h0;
			ms_pre_reg <= 10'h0;
			hb_ms_reg <= 16'h0;
			hb_pend_reg <= 1'b0;
			connection_open_done <= 1'b0;
		end
		else
		begin
			us_pre_reg <= us_tick ? 8'h0 : us_pre_reg + 8'h1;
			if (us_tick)
				ms_pre_reg <= ms_tick ? 10'h0 : ms_pre_reg + 10'h1;
			connection_open_done <= open_now;
			if (!open_now || hb_due)
				hb_ms_reg <= 16'h0;
			else if (ms_tick)
				hb_ms_reg <= hb_ms_reg + 16'h1;
			if (!open_now || (hbp_eff == 16'h0))
				hb_pend_reg <= 1'b0;
			else if (open_rise || hb_due)
				hb_pend_reg <= 1'b1;
			else if (state_reg == rure_pkg::RURE_S_IDLE)
				hb_pend_reg <= 1'b0;
		end
	end

	// request engine
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= rure_pkg::RURE_S_IDLE;
			cmd_pend_reg <= 1'b0;
			cmd_kind_reg <= rure_pkg::RURE_K_WR;
			cur_hb_reg <= 1'b0;
			hb_val_reg <= 16'h0;
			tmo_cnt_reg <= 16'h0;
			request_seq_id <= 16'h0;
			response_seq_id <= 16'h0;
			rx_area_head <= 16'h0;
			send_done <= 1'b0;
			receive_done <= 1'b0;
			response_timeout_err <= 1'b0;
			link.req_valid <= 1'b0;
			link.req_kind <= rure_pkg::RURE_K_HB;
			link.req_addr <= 16'h0;
			link.req_data <= 16'h0;
			link.req_flags <= 16'h0;
			link.req_seq <= 16'h0;
		end
		else
		begin
			send_done <= 1'b0;
			receive_done <= 1'b0;
			response_timeout_err <= 1'b0;
			if (cmd_go && open_now && !busy)
			begin
				cmd_pend_reg <= 1'b1;
				cmd_kind_reg <= rure_pkg::rure_kind_e'(pwdata[3:2]);
			end
			if (link.rsp_valid)
				response_seq_id <= link.rsp_seq;
			case (state_reg)
				rure_pkg::RURE_S_IDLE:
				begin
					if (hb_pend_reg && open_now)
					begin
						state_reg <= rure_pkg::RURE_S_SEND;
						cur_hb_reg <= 1'b1;
						hb_val_reg <= hb_val_reg + 16'h1;
						link.req_valid <= 1'b1;
						link.req_kind <= rure_pkg::RURE_K_HB;
						link.req_addr <= `RURE_BFM_HEARTBEAT;
						link.req_data <= hb_val_reg + 16'h1;
						link.req_flags <= 16'h0;
					end
					else if (cmd_pend_reg)
					begin
						state_reg <= rure_pkg::RURE_S_SEND;
						cmd_pend_reg <= 1'b0;
						cur_hb_reg <= 1'b0;
						link.req_valid <= 1'b1;
						link.req_kind <= cmd_kind_reg;
						link.req_addr <= addr_reg;
						link.req_data <= data_reg;
						link.req_flags <= (cmd_kind_reg == rure_pkg::RURE_K_WR) ? flags_reg : 16'h0;
						if (cmd_kind_reg == rure_pkg::RURE_K_RD)
						begin
							request_seq_id <= request_seq_id + 16'h1;
							link.req_seq <= request_seq_id + 16'h1;
						end
					end
				end
				rure_pkg::RURE_S_SEND:
				begin
					if (hs)
					begin
						link.req_valid <= 1'b0;
						tmo_cnt_reg <= 16'h0;
						send_done <= !cur_hb_reg;
						if (!cur_hb_reg && (link.req_kind == rure_pkg::RURE_K_RD))
							state_reg <= rure_pkg::RURE_S_WAIT;
						else
							state_reg <= rure_pkg::RURE_S_IDLE;
					end
				end
				rure_pkg::RURE_S_WAIT:
				begin
					if (match || expire || drop)
						state_reg <= rure_pkg::RURE_S_IDLE;
					if (match)
					begin
						receive_done <= 1'b1;
						rx_area_head <= link.rsp_data;
					end
					response_timeout_err <= expire;
					if (us_tick)
						tmo_cnt_reg <= tmo_cnt_reg + 16'h1;
				end
				default: state_reg <= rure_pkg::RURE_S_IDLE;
			endcase
		end
	end

	// error bits and codes; a new error wins over a clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conn_open_err <= 1'b0;
			tx_err <= 1'b0;
			rx_err <= 1'b0;
			conn_open_err_code <= 16'h0;
			tx_err_code <= 16'h0;
			rx_err_code <= 16'h0;
		end
		else
		begin
			if (open_fail)
			begin
				conn_open_err <= 1'b1;
				conn_open_err_code <= `RURE_ERR_OPEN_NOLINK;
			end
			else if (w_err && pwdata[0])
				conn_open_err <= 1'b0;
			if (tx_fail)
			begin
				tx_err <= 1'b1;
				tx_err_code <= `RURE_ERR_TX_NOTOPEN;
			end
			else if (w_err && pwdata[1])
				tx_err <= 1'b0;
			if (drop)
			begin
				rx_err <= 1'b1;
				rx_err_code <= `RURE_ERR_RX_LINKDROP;
			end
			else if (w_err && pwdata[2])
				rx_err <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: sim/rure_properties.sv */
// link checker for the request exchange
`timescale 1ns/1ps
`default_nettype none
`include "rure_map.svh"
module rure_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [1:0] req_kind,
	input wire logic [15:0] req_addr,
	input wire logic [15:0] req_data,
	input wire logic [15:0] req_flags,
	input wire logic [15:0] req_seq,
	input wire logic rsp_valid,
	input wire logic [15:0] rsp_seq,
	input wire logic [15:0] rsp_data
);
	logic [15:0] rd_seq_reg;
	logic [15:0] hb_reg;
	logic hb_seen_reg;
	// handshake decodes
	wire rd_hs = req_valid && req_ready && req_kind == rure_pkg::RURE_K_RD;
	wire hb_hs = req_valid && req_ready && req_kind == rure_pkg::RURE_K_HB;
	// last read id and last heartbeat value
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_seq_reg <= 16'h0000;
			hb_reg <= 16'h0000;
			hb_seen_reg <= 1'b0;
		end
		else
		begin
			if (rd_hs) rd_seq_reg <= req_seq;
			if (hb_hs) hb_reg <= req_data;
			if (hb_hs) hb_seen_reg <= 1'b1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rd_hs;
		rd_hs;
	endsequence
	sequence s_wait;
		req_valid && !req_ready;
	endsequence
	property p_hold;
		s_wait |=> req_valid && $stable(req_addr) && $stable(req_data) && $stable(req_seq);
	endproperty
	property p_drop;
		s_rd_hs |=> !req_valid;
	endproperty
	property p_seq;
		s_rd_hs |-> req_seq == rd_seq_reg + 16'h0001;
	endproperty
	property p_rsp_seq;
		rsp_valid |-> rsp_seq == rd_seq_reg;
	endproperty
	property p_rsp_time;
		s_rd_hs |-> ##[1:1000] rsp_valid;
	endproperty
	property p_busy;
		s_rd_hs |=> !req_ready until rsp_valid;
	endproperty
	property p_hb_addr;
		req_valid && req_kind == rure_pkg::RURE_K_HB |-> req_addr == `RURE_BFM_HEARTBEAT;
	endproperty
	property p_hb_chg;
		hb_hs && hb_seen_reg |-> req_data != hb_reg;
	endproperty
	a_hold: assert property (p_hold) else $error("request changed before handshake");
	a_drop: assert property (p_drop) else $error("read request not released");
	a_seq: assert property (p_seq) else $error("read id not incremented");
	a_rsp_seq: assert property (p_rsp_seq) else $error("response id differs");
	a_rsp_time: assert property (p_rsp_time) else $error("no response to read");
	a_busy: assert property (p_busy) else $error("second request accepted");
	a_hb_addr: assert property (p_hb_addr) else $error("heartbeat to wrong word");
	a_hb_chg: assert property (p_hb_chg) else $error("heartbeat value unchanged");
endmodule
`default_nettype wire

/* File: sim/rure_tb.sv */
// self-checking bench for both ends of the request exchange
`timescale 1ns/1ps
`default_nettype none
`include "rure_map.svh"
module rure_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cable_link_ok, hold_rsp, last_err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] peek_addr, peek_value, comm_status, heartbeat_word;
	logic [7:0] peek_flags;
	logic connection_open_done, send_done, receive_done, response_timeout_err, cable_link_err;
	int error_cnt, compares, n_sd, n_rcv, n_to;
	rure_link_if lnk();
	rure_ctrl i_rure_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.cable_link_ok, .connection_open_done, .send_done, .receive_done, .response_timeout_err, .cable_link_err,
		.link(lnk.ctrl));
	rure_unit #(.HB_LIMIT(64'd2000)) i_rure_unit (.pclk, .presetn, .link(lnk.unit), .hold_rsp, .peek_addr,
		.peek_value, .peek_flags, .comm_status, .heartbeat_word);
	rure_properties i_rure_properties (.pclk(pclk), .presetn(presetn), .req_valid(lnk.req_valid),
		.req_ready(lnk.req_ready), .req_kind(lnk.req_kind), .req_addr(lnk.req_addr), .req_data(lnk.req_data),
		.req_flags(lnk.req_flags), .req_seq(lnk.req_seq), .rsp_valid(lnk.rsp_valid), .rsp_seq(lnk.rsp_seq),
		.rsp_data(lnk.rsp_data));
	always #2.5 pclk = ~pclk;
	// pulse counters
	always @(posedge pclk)
	begin
		n_sd += int'(send_done === 1'b1);
		n_rcv += int'(receive_done === 1'b1);
		n_to += int'(response_timeout_err === 1'b1);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask
	task automatic launch(input logic [1:0] k, input logic [15:0] a, input logic [15:0] d, input logic [15:0] f);
		wr(`RURE_REG_ADDR, {16'h0000, a});
		wr(`RURE_REG_DATA, {16'h0000, d});
		wr(`RURE_REG_FLAGS, {16'h0000, f});
		wr(`RURE_REG_CTRL, {28'h0000000, k, 2'b11});
		waitc(30);
	endtask
	task automatic peek(input logic [15:0] a, input logic [31:0] e);
		peek_addr <= a;
		waitc(3);
		chk({8'h00, peek_flags, peek_value}, e);
	endtask
	// hang guard
	initial
	begin
		#100us;
		error_cnt++;
		end_sim();
	end
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, cable_link_ok, hold_rsp} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		peek_addr = 16'h0000;
		waitc(8);
		chk(cable_link_err, 1'b1);
		presetn <= 1'b1;
		@(posedge pclk);
		// errors with the cable down
		wr(`RURE_REG_CTRL, 32'h0000_0001);
		wr(`RURE_REG_CTRL, 32'h0000_0007);
		rd(`RURE_REG_ERR, 32'h0000_000B);
		rd(`RURE_REG_CODE, 32'h0002_0001);
		wr(`RURE_REG_CTRL, 32'h0000_0000);
		wr(`RURE_REG_ERR, 32'h0000_0007);
		rd(`RURE_REG_ERR, 32'h0000_0008);
		apb(1'b0, 8'h30, 32'h0000_0000);
		chk(last_err, 1'b1);
		cable_link_ok <= 1'b1;
		waitc(6);
		chk(cable_link_err, 1'b0);
		// heartbeat off, then on at open
		wr(`RURE_REG_HBP, 32'h0000_0000);
		wr(`RURE_REG_CTRL, 32'h0000_0001);
		waitc(40);
		chk(heartbeat_word, 16'h0000);
		chk(comm_status[0], 1'b0);
		wr(`RURE_REG_CTRL, 32'h0000_0000);
		wr(`RURE_REG_HBP, 32'h0000_0001);
		wr(`RURE_REG_CTRL, 32'h0000_0001);
		waitc(20);
		chk(connection_open_done, 1'b1);
		chk(comm_status[0], 1'b1);
		wr(`RURE_REG_HBP, 32'h0000_0000);
		waitc(2100);
		chk(comm_status[0], 1'b0);
		wr(`RURE_REG_HBP, 32'h0000_0001);
		wr(`RURE_REG_CTRL, 32'h0000_0000);
		wr(`RURE_REG_CTRL, 32'h0000_0001);
		waitc(20);
		chk(comm_status[0], 1'b1);
		chk(heartbeat_word, 16'h0002);
		chk(n_sd, 0);
		wr(`RURE_REG_HBP, 32'h0000_EA61);
		rd(`RURE_REG_HBP, 32'h0000_EA60);
		wr(`RURE_REG_HBP, 32'h0000_0000);
		// value and flag writes, all but the last (1025) aliasing one word
		launch(2'd3, 16'd256, 16'h0022, 16'h0000);
		launch(2'd1, 16'd256, 16'h00AA, 16'h0177);
		chk(n_sd, 2);
		peek(16'd256, 32'h0022_00AA);
		launch(2'd1, 16'd1024, 16'h5555, 16'h0133);
		peek(16'd256, 32'h0022_00AA);
		launch(2'd3, 16'd1536, 16'h0044, 16'h0000);
		peek(16'd256, 32'h0022_00AA);
		launch(2'd3, 16'd16896, 16'h0066, 16'h0000);
		peek(16'd256, 32'h0022_00AA);
		launch(2'd1, 16'd1025, 16'h1234, 16'h0155);
		peek(16'd1025, 32'h0055_1234);
		// reads, a timeout and a stale answer
		wr(`RURE_REG_TMO, 32'h0000_0064);
		launch(2'd2, 16'd1025, 16'h0000, 16'h0000);
		chk(n_rcv, 1);
		rd(`RURE_REG_RXD, 32'h0000_1234);
		rd(`RURE_REG_SEQ, 32'h0001_0001);
		hold_rsp <= 1'b1;
		wr(`RURE_REG_TMO, 32'h0000_0001);
		launch(2'd2, 16'd1025, 16'h0000, 16'h0000);
		waitc(400);
		chk(n_to, 1);
		// a write held at the link while the unit still owes the stale answer
		launch(2'd1, 16'd1, 16'h0BEE, 16'h0000);
		hold_rsp <= 1'b0;
		waitc(10);
		chk(n_rcv, 1);
		peek(16'd1, 32'h0055_0BEE);
		launch(2'd2, 16'd256, 16'h0000, 16'h0000);
		chk(n_rcv, 2);
		chk(n_to, 1);
		rd(`RURE_REG_RXD, 32'h0000_00AA);
		rd(`RURE_REG_SEQ, 32'h0003_0003);
		// cable lost while a read waits
		hold_rsp <= 1'b1;
		launch(2'd2, 16'd256, 16'h0000, 16'h0000);
		rd(`RURE_REG_STAT, 32'h0000_000E);
		cable_link_ok <= 1'b0;
		waitc(6);
		rd(`RURE_REG_ERR, 32'h0000_000C);
		apb(1'b0, `RURE_REG_RXCODE, 32'h0000_0000);
		chk(q, 32'h0000_0003);
		hold_rsp <= 1'b0;
		waitc(10);
		chk(n_rcv, 2);
		chk(n_to, 1);
		end_sim();
	end
endmodule
`default_nettype wire
